// ===== verilog/secnt_top.sv
// Overview of operation
// - first substrate pulse delayed 0..8191 lines after the primary gate line
// - sense-gate pulses enabled every field unless masked
// - 13-bit substrate mask field count covers exposure plus readout
// - 13-bit exposure field count suppresses sense-gate pulses
// - skip-first-mask leaves the first counted field unmasked
// - 1..8191 substrate pulses per field, one per consecutive line
// - gate inhibit kills sense-gate, substrate train still runs its count
// - two 14-bit toggles place the pulse; line starts at set polarity
// - two 14-bit fine toggles; update at gate line or field sync
// - primary, secondary counters advance once per field sync
// - primary counter drives masking, repeating mode reapplies it each cycle
// - secondary counter never touches substrate or sense-gate outputs
// - action 0 keeps the counter idle
// - action 1 counts once from 1 to maximum then idles
// - action 2 wraps at maximum and repeats
// - action 3 waits the delay then counts once
// - action 4 repeats with the delay between repetitions
// - action 5 holds exposure with both masks until readout or idle
// - action 6 enters readout with sense-gate active; 7 forces idle
// - 13-bit primary maximum, 12-bit secondary maximum
// - 13-bit field delay; skip applies it only before first repeat
// - 3-bit control masks field and line sync outputs while the selected counter is busy
// - polarity, toggles, count, start delay take effect after gate line
// - fine pulse omitted when both fine toggles are all ones
// - field after activation is the first masked exposure field
// - zero mask counts leave outputs as in normal shuttering
module secnt_top
  import secnt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  input  wire logic         field_sync_in,
  input  wire logic         line_sync_in,
  input  wire logic         gate_line_in,
  output logic              substrate_clear_pulse,
  output logic              sense_gate_enable,
  output logic              field_sync_out,
  output logic              line_sync_out,
  output logic              aux_counter_busy,
  output logic [FLD_W-1:0]  aux_counter_count
);

  secnt_top_st_t s_q;
  secnt_top_st_t s_d;

  secnt_fc_if main_fc ();
  secnt_fc_if aux_fc ();

  function automatic logic mask_hit(input logic [FLD_W-1:0] idx, input logic [FLD_W-1:0] lim);
    mask_hit = (idx != '0) && (idx <= lim);
  endfunction

  // field index as seen by the masks, shifted when the first field is skipped
  logic [FLD_W-1:0] mask_idx;
  logic             sub_mask;
  logic             gate_mask;
  logic             sel_busy;
  logic             addr_ok;
  logic [IDX_W-1:0] line_end;
  logic             fine_en;
  logic             tog_hit;
  logic             fine_hit;

  always_comb begin
    mask_idx  = s_q.regs.skip_first ? main_fc.count - FLD_W'(1) : main_fc.count;
    // only the primary counter enters these terms
    sub_mask  = (main_fc.counting && mask_hit(mask_idx, s_q.regs.sub_fields))
              || main_fc.expose || main_fc.readout;
    gate_mask = (main_fc.counting && mask_hit(mask_idx, s_q.regs.exp_fields))
              || main_fc.expose;
    sel_busy  = s_q.regs.sync_mask[SYNC_SEL_AUX] ? aux_fc.busy : main_fc.busy;
    addr_ok   = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && (hsize == HSIZE_WORD);
    line_end  = IDX_W'({1'b0, s_q.shd.start_dly}) + IDX_W'({1'b0, s_q.shd.pulses});
    fine_en   = !((s_q.fine1_s == FINE_OFF) && (s_q.fine2_s == FINE_OFF));
    tog_hit   = (s_q.px == s_q.shd.tog1) ^ (s_q.px == s_q.shd.tog2);
    fine_hit  = (s_q.px == s_q.fine1_s) ^ (s_q.px == s_q.fine2_s);
  end

  always_comb begin
    s_d = s_q;

    // bus address phase: read data is captured here, writes land next cycle
    s_d.wr_pend = addr_ok && hwrite;
    s_d.wr_addr = haddr[AW-1:0];
    s_d.main_wr = 1'b0;
    s_d.aux_wr  = 1'b0;
    s_d.rdata   = '0;
    if (addr_ok && !hwrite) begin
      case (haddr[AW-1:0])
        OFS_CTRL: begin
          s_d.rdata[CTRL_SKIP]     = s_q.regs.skip_first;
          s_d.rdata[CTRL_INHIBIT]  = s_q.regs.inhibit;
          s_d.rdata[CTRL_POL]      = s_q.regs.pol;
          s_d.rdata[CTRL_FINE_SEL] = s_q.regs.fine_sel;
        end
        OFS_MASKS: begin
          s_d.rdata[FLD_W-1:0]             = s_q.regs.exp_fields;
          s_d.rdata[HI_LSB +: FLD_W]       = s_q.regs.sub_fields;
        end
        OFS_PULSE: begin
          s_d.rdata[FLD_W-1:0]             = s_q.regs.start_dly;
          s_d.rdata[HI_LSB +: FLD_W]       = s_q.regs.pulses;
        end
        OFS_TOG: begin
          s_d.rdata[PIX_W-1:0]             = s_q.regs.tog1;
          s_d.rdata[HI_LSB +: PIX_W]       = s_q.regs.tog2;
        end
        OFS_FINE: begin
          s_d.rdata[PIX_W-1:0]             = s_q.regs.fine1;
          s_d.rdata[HI_LSB +: PIX_W]       = s_q.regs.fine2;
        end
        OFS_MAIN_ACT: begin
          s_d.rdata[ACT_W-1:0]             = s_q.regs.main_act;
          s_d.rdata[SYNC_LSB +: SYNC_W]    = s_q.regs.sync_mask;
        end
        OFS_AUX_ACT: begin
          s_d.rdata[ACT_W-1:0]             = s_q.regs.aux_act;
        end
        OFS_LIMITS: begin
          s_d.rdata[FLD_W-1:0]             = s_q.regs.main_lim;
          s_d.rdata[HI_LSB +: AUX_W]       = s_q.regs.aux_lim;
        end
        OFS_MAIN_DLY: begin
          s_d.rdata[FLD_W-1:0]             = s_q.regs.main_dly;
          s_d.rdata[DLY_SKIP_BIT]          = s_q.regs.main_skip;
        end
        OFS_AUX_DLY: begin
          s_d.rdata[FLD_W-1:0]             = s_q.regs.aux_dly;
          s_d.rdata[DLY_SKIP_BIT]          = s_q.regs.aux_skip;
        end
        OFS_STATUS: begin
          s_d.rdata[FLD_W-1:0]             = main_fc.count;
          s_d.rdata[HI_LSB +: FLD_W]       = aux_fc.count;
          s_d.rdata[ST_MAIN_BUSY]          = main_fc.busy;
          s_d.rdata[ST_AUX_BUSY]           = aux_fc.busy;
          s_d.rdata[ST_GATE_MASK]          = gate_mask;
          s_d.rdata[ST_SUB_MASK]           = sub_mask;
        end
        default: s_d.rdata = '0;
      endcase
    end

    // bus data phase
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        OFS_CTRL: begin
          s_d.regs.skip_first = hwdata[CTRL_SKIP];
          s_d.regs.inhibit    = hwdata[CTRL_INHIBIT];
          s_d.regs.pol        = hwdata[CTRL_POL];
          s_d.regs.fine_sel   = hwdata[CTRL_FINE_SEL];
        end
        OFS_MASKS: begin
          s_d.regs.exp_fields = hwdata[FLD_W-1:0];
          s_d.regs.sub_fields = hwdata[HI_LSB +: FLD_W];
        end
        OFS_PULSE: begin
          s_d.regs.start_dly  = hwdata[FLD_W-1:0];
          s_d.regs.pulses     = hwdata[HI_LSB +: FLD_W];
        end
        OFS_TOG: begin
          s_d.regs.tog1       = hwdata[PIX_W-1:0];
          s_d.regs.tog2       = hwdata[HI_LSB +: PIX_W];
        end
        OFS_FINE: begin
          s_d.regs.fine1      = hwdata[PIX_W-1:0];
          s_d.regs.fine2      = hwdata[HI_LSB +: PIX_W];
        end
        OFS_MAIN_ACT: begin
          s_d.regs.main_act   = hwdata[ACT_W-1:0];
          s_d.regs.sync_mask  = hwdata[SYNC_LSB +: SYNC_W];
          s_d.main_wr         = 1'b1;
        end
        OFS_AUX_ACT: begin
          s_d.regs.aux_act    = hwdata[ACT_W-1:0];
          s_d.aux_wr          = 1'b1;
        end
        OFS_LIMITS: begin
          s_d.regs.main_lim   = hwdata[FLD_W-1:0];
          s_d.regs.aux_lim    = hwdata[HI_LSB +: AUX_W];
        end
        OFS_MAIN_DLY: begin
          s_d.regs.main_dly   = hwdata[FLD_W-1:0];
          s_d.regs.main_skip  = hwdata[DLY_SKIP_BIT];
        end
        OFS_AUX_DLY: begin
          s_d.regs.aux_dly    = hwdata[FLD_W-1:0];
          s_d.regs.aux_skip   = hwdata[DLY_SKIP_BIT];
        end
        default: begin
        end
      endcase
    end

    // pixel position inside the current line
    s_d.px = line_sync_in ? '0 : s_q.px + PIX_W'(1);

    if (gate_line_in) begin
      s_d.gate_pend = 1'b1;
    end
    if (field_sync_in && s_q.regs.fine_sel) begin
      s_d.fine1_s = s_q.regs.fine1;
      s_d.fine2_s = s_q.regs.fine2;
    end

    if (line_sync_in) begin
      if (s_q.gate_pend) begin
        // settings change only here so a field never sees a half-updated train
        s_d.shd.pol       = s_q.regs.pol;
        s_d.shd.tog1      = s_q.regs.tog1;
        s_d.shd.tog2      = s_q.regs.tog2;
        s_d.shd.start_dly = s_q.regs.start_dly;
        s_d.shd.pulses    = s_q.regs.pulses;
        if (!s_q.regs.fine_sel) begin
          s_d.fine1_s = s_q.regs.fine1;
          s_d.fine2_s = s_q.regs.fine2;
        end
        // a gate line that starts on this very line sync arms the next field
        s_d.gate_pend = gate_line_in;
        s_d.run       = 1'b1;
        s_d.line_idx  = '0;
      end else if (s_q.run) begin
        s_d.line_idx = s_q.line_idx + IDX_W'(1);
        if (s_q.line_idx + IDX_W'(1) >= line_end) begin
          s_d.run = 1'b0;
        end
      end
      s_d.pulse_line = s_d.run && (s_d.line_idx >= IDX_W'({1'b0, s_d.shd.start_dly}))
                     && (s_d.line_idx < IDX_W'({1'b0, s_d.shd.start_dly})
                                        + IDX_W'({1'b0, s_d.shd.pulses}));
      s_d.last_line  = s_d.pulse_line
                     && (s_d.line_idx + IDX_W'(1) == IDX_W'({1'b0, s_d.shd.start_dly})
                                                   + IDX_W'({1'b0, s_d.shd.pulses}));
      s_d.line_sub_mask = sub_mask;
      s_d.sub           = s_d.shd.pol;
    end else if (s_q.pulse_line && !s_q.line_sub_mask) begin
      s_d.sub = s_q.sub ^ tog_hit ^ (s_q.last_line && fine_en && fine_hit);
    end

    s_d.gate_en = !(s_q.regs.inhibit || gate_mask);
    s_d.fs_out  = field_sync_in && !(s_q.regs.sync_mask[SYNC_FIELD] && sel_busy);
    s_d.ls_out  = line_sync_in && !(s_q.regs.sync_mask[SYNC_LINE] && sel_busy);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q             <= '0;
      s_q.regs.pulses <= PULSES_RST;
      s_q.regs.fine1  <= FINE_RST;
      s_q.regs.fine2  <= FINE_RST;
      s_q.fine1_s     <= FINE_RST;
      s_q.fine2_s     <= FINE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign main_fc.act_wr      = s_q.main_wr;
  assign main_fc.action      = s_q.regs.main_act;
  assign main_fc.limit       = s_q.regs.main_lim;
  assign main_fc.delay       = s_q.regs.main_dly;
  assign main_fc.skip        = s_q.regs.main_skip;
  assign main_fc.field_tick  = field_sync_in;
  assign main_fc.readout_len = (s_q.regs.sub_fields > s_q.regs.exp_fields)
                             ? s_q.regs.sub_fields - s_q.regs.exp_fields : '0;

  assign aux_fc.act_wr       = s_q.aux_wr;
  assign aux_fc.action       = s_q.regs.aux_act;
  assign aux_fc.limit        = FLD_W'({1'b0, s_q.regs.aux_lim});
  assign aux_fc.delay        = s_q.regs.aux_dly;
  assign aux_fc.skip         = s_q.regs.aux_skip;
  assign aux_fc.field_tick   = field_sync_in;
  assign aux_fc.readout_len  = '0;

  secnt_field_counter #(
    .HAS_MANUAL (1'b1)
  ) u_main_cnt (
    .clk (clk),
    .rst (rst),
    .fc  (main_fc)
  );

  // manual exposure and readout belong to the primary counter only
  secnt_field_counter #(
    .HAS_MANUAL (1'b0)
  ) u_aux_cnt (
    .clk (clk),
    .rst (rst),
    .fc  (aux_fc)
  );

  assign hreadyout             = 1'b1;
  assign hresp                 = HRESP_OKAY;
  assign hrdata                = s_q.rdata;
  assign substrate_clear_pulse = s_q.sub;
  assign sense_gate_enable     = s_q.gate_en;
  assign field_sync_out        = s_q.fs_out;
  assign line_sync_out         = s_q.ls_out;
  assign aux_counter_busy      = aux_fc.busy;
  assign aux_counter_count     = aux_fc.count;

endmodule // secnt_top

// ===== inc/secnt_pkg.sv
package secnt_pkg;

  localparam int PIX_W     = 14;
  localparam int FLD_W     = 13;
  localparam int AUX_W     = 12;
  localparam int ACT_W     = 3;
  localparam int IDX_W     = 14;
  localparam int SYNC_W    = 3;
  localparam int AW        = 8;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_MASKS    = 8'h04;
  localparam logic [AW-1:0] OFS_PULSE    = 8'h08;
  localparam logic [AW-1:0] OFS_TOG      = 8'h0C;
  localparam logic [AW-1:0] OFS_FINE     = 8'h10;
  localparam logic [AW-1:0] OFS_MAIN_ACT = 8'h14;
  localparam logic [AW-1:0] OFS_AUX_ACT  = 8'h18;
  localparam logic [AW-1:0] OFS_LIMITS   = 8'h1C;
  localparam logic [AW-1:0] OFS_MAIN_DLY = 8'h20;
  localparam logic [AW-1:0] OFS_AUX_DLY  = 8'h24;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h28;

  // field positions
  localparam int CTRL_SKIP     = 0;
  localparam int CTRL_INHIBIT  = 1;
  localparam int CTRL_POL      = 2;
  localparam int CTRL_FINE_SEL = 3;
  localparam int HI_LSB        = 16;
  localparam int SYNC_LSB      = 8;
  localparam int DLY_SKIP_BIT  = 16;
  localparam int ST_MAIN_BUSY  = 31;
  localparam int ST_AUX_BUSY   = 30;
  localparam int ST_GATE_MASK  = 29;
  localparam int ST_SUB_MASK   = 28;
  localparam int SYNC_FIELD    = 0;
  localparam int SYNC_LINE     = 1;
  localparam int SYNC_SEL_AUX  = 2;

  // reset values
  localparam logic [FLD_W-1:0] PULSES_RST = 13'h0001;
  localparam logic [PIX_W-1:0] FINE_RST   = 14'h3FFF;
  localparam logic [PIX_W-1:0] FINE_OFF   = 14'h3FFF;

  // action codes
  localparam logic [ACT_W-1:0] ACT_IDLE         = 3'h0;
  localparam logic [ACT_W-1:0] ACT_SINGLE       = 3'h1;
  localparam logic [ACT_W-1:0] ACT_REPEAT       = 3'h2;
  localparam logic [ACT_W-1:0] ACT_DELAYED      = 3'h3;
  localparam logic [ACT_W-1:0] ACT_DELAY_REPEAT = 3'h4;
  localparam logic [ACT_W-1:0] ACT_EXPOSE       = 3'h5;
  localparam logic [ACT_W-1:0] ACT_READOUT      = 3'h6;
  localparam logic [ACT_W-1:0] ACT_FORCE_IDLE   = 3'h7;

  // bus constants
  localparam int         HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD        = 3'h2;
  localparam logic       HRESP_OKAY        = 1'b0;

  typedef enum logic [2:0] {
    CS_IDLE, CS_ARMED, CS_DELAY, CS_COUNT, CS_EXPOSE, CS_READOUT
  } secnt_cst_t;

  typedef struct packed {
    secnt_cst_t         st;
    logic [ACT_W-1:0]   mode;
    logic [FLD_W-1:0]   cnt;
    logic [FLD_W-1:0]   dly;
    logic [FLD_W-1:0]   rd;
  } secnt_cnt_st_t;

  typedef struct packed {
    logic               skip_first;
    logic               inhibit;
    logic               pol;
    logic               fine_sel;
    logic [FLD_W-1:0]   exp_fields;
    logic [FLD_W-1:0]   sub_fields;
    logic [FLD_W-1:0]   start_dly;
    logic [FLD_W-1:0]   pulses;
    logic [PIX_W-1:0]   tog1;
    logic [PIX_W-1:0]   tog2;
    logic [PIX_W-1:0]   fine1;
    logic [PIX_W-1:0]   fine2;
    logic [ACT_W-1:0]   main_act;
    logic [ACT_W-1:0]   aux_act;
    logic [SYNC_W-1:0]  sync_mask;
    logic [FLD_W-1:0]   main_lim;
    logic [AUX_W-1:0]   aux_lim;
    logic [FLD_W-1:0]   main_dly;
    logic               main_skip;
    logic [FLD_W-1:0]   aux_dly;
    logic               aux_skip;
  } secnt_regs_t;

  typedef struct packed {
    logic               pol;
    logic [PIX_W-1:0]   tog1;
    logic [PIX_W-1:0]   tog2;
    logic [FLD_W-1:0]   start_dly;
    logic [FLD_W-1:0]   pulses;
  } secnt_shadow_t;

  typedef struct packed {
    secnt_regs_t        regs;
    secnt_shadow_t      shd;
    logic [PIX_W-1:0]   fine1_s;
    logic [PIX_W-1:0]   fine2_s;
    logic               wr_pend;
    logic [AW-1:0]      wr_addr;
    logic [31:0]        rdata;
    logic               main_wr;
    logic               aux_wr;
    logic               gate_pend;
    logic               run;
    logic [IDX_W-1:0]   line_idx;
    logic               pulse_line;
    logic               last_line;
    logic               line_sub_mask;
    logic [PIX_W-1:0]   px;
    logic               sub;
    logic               gate_en;
    logic               fs_out;
    logic               ls_out;
  } secnt_top_st_t;

endpackage

// ===== inc/secnt_fc_if.sv
interface secnt_fc_if;
  import secnt_pkg::*;
  logic               act_wr;
  logic [ACT_W-1:0]   action;
  logic [FLD_W-1:0]   limit;
  logic [FLD_W-1:0]   delay;
  logic [FLD_W-1:0]   readout_len;
  logic               skip;
  logic               field_tick;
  logic               busy;
  logic               counting;
  logic               expose;
  logic               readout;
  logic [FLD_W-1:0]   count;

  modport ctl (output act_wr, action, limit, delay, readout_len, skip, field_tick,
               input  busy, counting, expose, readout, count);
  modport cnt (input  act_wr, action, limit, delay, readout_len, skip, field_tick,
               output busy, counting, expose, readout, count);
endinterface

// ===== verilog/secnt_field_counter.sv
module secnt_field_counter
  import secnt_pkg::*;
#(
  parameter bit HAS_MANUAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  secnt_fc_if.cnt  fc
);

  secnt_cnt_st_t s_q;
  secnt_cnt_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (fc.field_tick) begin
      unique case (s_q.st)
        CS_IDLE: begin
        end
        CS_ARMED: begin
          s_d.st  = CS_COUNT;
          s_d.cnt = FLD_W'(1);
        end
        CS_DELAY: begin
          if (s_q.dly >= fc.delay) begin
            s_d.st  = CS_COUNT;
            s_d.cnt = FLD_W'(1);
          end else begin
            s_d.dly = s_q.dly + FLD_W'(1);
          end
        end
        CS_COUNT: begin
          if (s_q.cnt >= fc.limit) begin
            if (s_q.mode == ACT_REPEAT) begin
              s_d.cnt = FLD_W'(1);
            end else if (s_q.mode == ACT_DELAY_REPEAT) begin
              // skip option: delay only ahead of the first count
              if (fc.skip || fc.delay == '0) begin
                s_d.cnt = FLD_W'(1);
              end else begin
                s_d.st  = CS_DELAY;
                s_d.dly = FLD_W'(1);
              end
            end else begin
              s_d.st = CS_IDLE;
            end
          end else begin
            s_d.cnt = s_q.cnt + FLD_W'(1);
          end
        end
        CS_EXPOSE: begin
        end
        CS_READOUT: begin
          if (s_q.rd >= fc.readout_len) begin
            s_d.st = CS_IDLE;
          end else begin
            s_d.rd = s_q.rd + FLD_W'(1);
          end
        end
        default: s_d.st = CS_IDLE;
      endcase
    end
    // a fresh command overrides the state and mode that the field tick left
    if (fc.act_wr) begin
      s_d.mode = fc.action;
      unique case (fc.action)
        ACT_IDLE, ACT_FORCE_IDLE: s_d.st = CS_IDLE;
        ACT_SINGLE, ACT_REPEAT: begin
          s_d.st  = CS_ARMED;
          s_d.cnt = '0;
        end
        ACT_DELAYED, ACT_DELAY_REPEAT: begin
          s_d.st  = CS_DELAY;
          s_d.dly = '0;
          s_d.cnt = '0;
        end
        ACT_EXPOSE: begin
          s_d.st = HAS_MANUAL ? CS_EXPOSE : CS_IDLE;
        end
        ACT_READOUT: begin
          s_d.st = HAS_MANUAL ? CS_READOUT : CS_IDLE;
          s_d.rd = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fc.busy     = (s_q.st != CS_IDLE);
  assign fc.counting = (s_q.st == CS_COUNT);
  assign fc.expose   = (s_q.st == CS_EXPOSE);
  assign fc.readout  = (s_q.st == CS_READOUT);
  assign fc.count    = s_q.cnt;

endmodule // secnt_field_counter

// ===== tb/secnt_checker.sv
module secnt_checker
  import secnt_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             field_sync_in,
  input wire logic             line_sync_in,
  input wire logic             substrate_clear_pulse,
  input wire logic             sense_gate_enable,
  input wire logic             field_sync_out,
  input wire logic             line_sync_out,
  input wire logic             aux_counter_busy,
  input wire logic [FLD_W-1:0] aux_counter_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic aux_wr_q;
  logic main_q;
  logic sub_q;
  wire  wr = hsel & htrans[1] & hready & hwrite;
  // main_q and sub_q stay set once touched, so the quiet checks only hold on untouched settings
  always_ff @(posedge clk) begin
    aux_wr_q <= wr && haddr[7:0] == OFS_AUX_ACT;
    main_q <= !rst && (main_q || wr && haddr[7:0] inside {OFS_CTRL, OFS_MAIN_ACT});
    sub_q <= !rst && (sub_q || wr && haddr[7:0] <= OFS_MAIN_ACT);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  fs_path_a: assert property (field_sync_out |-> $past(field_sync_in))
    else $error("field sync out without input");
  ls_path_a: assert property (line_sync_out |-> $past(line_sync_in))
    else $error("line sync out without input");
  fs_pass_a: assert property (!main_q && !$past(rst) |-> field_sync_out == $past(field_sync_in))
    else $error("field sync lost while unmasked");
  ls_pass_a: assert property (!main_q && !$past(rst) |-> line_sync_out == $past(line_sync_in))
    else $error("line sync lost while unmasked");
  gate_free_a: assert property (!main_q && !$past(rst) |-> sense_gate_enable)
    else $error("sense gate off without cause");
  sub_quiet_a: assert property (!sub_q |-> !substrate_clear_pulse)
    else $error("substrate moved on reset settings");
  aux_start_a: assert property ($rose(aux_counter_busy) |-> $past(aux_wr_q, 2))
    else $error("aux counter left idle without command");
  aux_step_a: assert property ($changed(aux_counter_count) && !$past(aux_wr_q, 2)
    |-> $past(field_sync_in) && (aux_counter_count == $past(aux_counter_count) + 1
    || aux_counter_count <= 1)) else $error("aux count stepped wrongly");
  cover property ($rose(aux_counter_busy));
  cover property ($fell(sense_gate_enable));
  cover property ($rose(substrate_clear_pulse));
endmodule // secnt_checker

bind secnt_top secnt_checker chk (.*);

// ===== tb/secnt_sync_model.sv
module secnt_sync_model #(
  parameter int LINE_CYC = 24,
  parameter int LINES    = 8
) (
  input wire logic clk,
  input wire logic rst,
  output logic     field_sync_in,
  output logic     line_sync_in,
  output logic     gate_line_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int px = 0;
  int ln = 0;
  always @(posedge clk) begin
    px <= rst || px == LINE_CYC - 1 ? 0 : px + 1;
    if (rst) ln <= 0;
    else if (px == LINE_CYC - 1) ln <= ln == LINES - 1 ? 0 : ln + 1;
  end
  assign line_sync_in = !rst && px == 0;
  assign field_sync_in = line_sync_in && ln == 0;
  // gate line is line 0, ahead of every pulse line it arms
  assign gate_line_in = !rst && ln == 0 && px == 3;
endmodule // secnt_sync_model

// ===== tb/test_shutter_exposure_field_counters.sv
module test_shutter_exposure_field_counters
  import secnt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, pv = 0, f_gate = 0;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, field_sync_in, line_sync_in, gate_line_in;
  logic substrate_clear_pulse, sense_gate_enable, field_sync_out, line_sync_out;
  logic aux_counter_busy;
  logic [FLD_W-1:0] aux_counter_count;
  int fails = 0, checks_done = 0, seed = 93769, ln = 0, rises = 0, first = 0, last = 0;
  int f_rises = 0, f_first = 0, f_last = 0, f_num = 0, nfo = 0, c, n, act, nlo = 0, m;
  int ma[4] = '{1, 1, 2, 2}, ms[4] = '{0, 1, 0, 0}, mz[4] = '{1, 1, 1, 0};
  logic [31:0] wm[12] = '{32'hF, 32'h1FFF1FFF, 32'h1FFF1FFF, 32'h3FFF3FFF, 32'h3FFF3FFF,
    32'h700, 32'h0, 32'h0FFF1FFF, 32'h11FFF, 32'h11FFF, 32'h0, 32'h0};
`define CMP(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
  secnt_top dut (.hready(hreadyout), .*);
  secnt_sync_model sm (.*);
  initial forever #12.5 clk = ~clk;
  initial begin
    #1500000;
    fails++;
    close_out();
  end
  // substrate train shape of each field, latched when the next field starts
  always @(posedge clk) begin
    pv <= substrate_clear_pulse;
    if (field_sync_out) nfo <= nfo + 1;
    if (line_sync_out) nlo <= nlo + 1;
    if (substrate_clear_pulse && !pv) begin
      if (rises == 0) first <= ln;
      last <= ln;
      rises <= rises + 1;
    end
    if (line_sync_in && ln == 3) f_gate <= sense_gate_enable;
    if (field_sync_in) begin
      f_rises <= rises;
      f_first <= first;
      f_last <= last;
      f_num <= f_num + 1;
      rises <= 0;
      ln <= 0;
    end else if (line_sync_in) ln <= ln + 1;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // waits out the current field, then lets the counter step land
  task automatic wf();
    int s;
    s = f_num;
    while (f_num == s) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // count after k field syncs: -1 while delaying, 0 once idle
  function automatic int model(int rep, int k, int l, int d, int g);
    int m;
    m = k - d - 1;
    if (m < 0) return -1;
    if (!rep && m >= l) return 0;
    return m % (l + g) < l ? m % (l + g) + 1 : -1;
  endfunction
  task automatic close_out();
    $display("mismatches %0d checks %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int a = 0; a < 48; a += 4) begin
      bus(0, a[7:0], 0);
      `CMP(rd, a == 8 ? 32'h10000 : a == 16 ? 32'h3FFF3FFF : 32'h0)
      n = $random(seed) & (a == 20 || a == 24 ? ~7 : ~0);
      bus(1, a[7:0], n);
      bus(0, a[7:0], 0);
      `CMP(rd, n & wm[a / 4])
    end
    $display("test registers done");
    bus(1, 8, 32'h30002);
    bus(1, 12, 32'hA0005);
    bus(1, 16, 32'h3FFF3FFF);
    bus(1, 0, 0);
    bus(1, 20, 0);
    wf();
    wf();
    `CMP(f_rises, 3)
    `CMP(f_first, 3)
    `CMP(f_last, 5)
    `CMP(f_gate, 1'b1)
    bus(1, 16, 32'h10000E);
    wf();
    wf();
    `CMP(f_rises, 4)
    bus(1, 0, 32'hA);
    bus(1, 16, 32'h3FFF3FFF);
    wf();
    wf();
    `CMP(f_gate, 1'b0)
    `CMP(f_rises, 3)
    bus(1, 16, 32'h10000E);
    bus(1, 28, 32'h30002);
    for (int i = 0; i < 4; i++) begin
      bus(1, 0, ms[i]);
      bus(1, 4, mz[i] ? 32'h20001 : 0);
      bus(1, 20, ma[i]);
      wf();
      for (int k = 1; k < 6; k++) begin
        wf();
        c = model(ma[i] == 2, k, 2, 0, 0) - ms[i];
        `CMP(f_gate, !(mz[i] && c == 1))
        `CMP(f_rises, mz[i] && c inside {[1:2]} ? 0 : 4)
      end
      bus(1, 20, 7);
      wf();
    end
    bus(1, 4, 32'h20001);
    bus(1, 20, 32'h305);
    wf();
    wf();
    n = nfo;
    m = nlo;
    wf();
    `CMP(f_gate, 1'b0)
    `CMP(f_rises, 0)
    `CMP(nfo - n, 0)
    `CMP(nlo - m, 0)
    bus(1, 20, 32'h306);
    wf();
    wf();
    `CMP(f_gate, 1'b1)
    bus(1, 20, 7);
    wf();
    n = nfo;
    m = nlo;
    wf();
    `CMP(nfo - n, 1)
    `CMP(nlo - m, 8)
    $display("test main counter done");
    for (int i = 0; i < 5; i++) begin
      act = i < 4 ? i + 1 : 4;
      bus(1, 36, ((i == 4) << 16) | 2);
      bus(1, 24, act);
      for (int k = 1; k < 11; k++) begin
        wf();
        c = model(act == 2 || act == 4, k, 3, act > 2 ? 2 : 0, i == 3 ? 2 : 0);
        `CMP(aux_counter_busy, c != 0)
        if (c > 0) `CMP(aux_counter_count, c)
      end
      bus(1, 24, 7);
      wf();
      `CMP(aux_counter_busy, 1'b0)
    end
    $display("test aux counter done");
    close_out();
  end
endmodule // test_shutter_exposure_field_counters
